// File: src/pfc_pkg.sv
/*
  constants, types and timing for the parallel flash host controller.
  assumes a 50 MHz clock and a byte-wide flash on asynchronous strobes.
*/
// Notes on behaviour
// - write only with select, strobe low, enable high
// - high voltage on reset pin unprotects sectors
// - address at later fall, data at first rise
// - the reset command or a hardware reset pulse leaves autoselect mode
// - after timing failure flag, host writes reset
// - byte program is four write cycles
package pfc_pkg;
  // ****************************************
  // widths and register map
  // ****************************************
  localparam int FA_W = 18;
  localparam int FD_W = 8;
  localparam int RA_W = 4;
  localparam int RD_W = 32;
  localparam int CNT_W = 6;
  localparam logic [RA_W-1:0] REG_CTRL = 4'h0;
  localparam logic [RA_W-1:0] REG_ADDR = 4'h4;
  localparam logic [RA_W-1:0] REG_DATA = 4'h8;
  localparam logic [RA_W-1:0] REG_STAT = 4'hc;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_UNPROT_BIT = 3;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_ERR_BIT = 9;
  localparam int STAT_AUTO_BIT = 10;
  localparam int STAT_UNPROT_BIT = 11;
  localparam int POLL_BIT = 7;
  localparam int FAIL_BIT = 5;
  // ****************************************
  // command encoding
  // ****************************************
  localparam logic [FA_W-1:0] UNLOCK_A1 = 18'h00555;
  localparam logic [FA_W-1:0] UNLOCK_A2 = 18'h002aa;
  localparam logic [FD_W-1:0] UNLOCK_D1 = 8'haa;
  localparam logic [FD_W-1:0] UNLOCK_D2 = 8'h55;
  localparam logic [FD_W-1:0] CMD_RESET = 8'hf0;
  localparam logic [FD_W-1:0] CMD_AUTO = 8'h90;
  localparam logic [FD_W-1:0] CMD_PROG = 8'ha0;
  localparam logic [2:0] STEP_LAST_UNLOCK = 3'h2;
  localparam logic [2:0] PROG_WRITES = 3'h4;
  // ****************************************
  // timing, in ns, then in clock cycles
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int T_SETUP_NS = 20;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 150;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int SYNC_STAGES = 3;
  function automatic int cyc_of(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [CNT_W-1:0] CYC_SETUP = CNT_W'(cyc_of(T_SETUP_NS));
  localparam logic [CNT_W-1:0] CYC_WP = CNT_W'(cyc_of(T_WP_NS));
  localparam logic [CNT_W-1:0] CYC_RD = CNT_W'(cyc_of(T_ACC_NS) + SYNC_STAGES);
  localparam logic [CNT_W-1:0] CYC_RP = CNT_W'(cyc_of(T_RP_NS));
  localparam logic [CNT_W-1:0] CYC_RH = CNT_W'(cyc_of(T_RH_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  // ****************************************
  // operations and states
  // ****************************************
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_RESET = 3'h1,
    OP_AUTO = 3'h2,
    OP_PROG = 3'h3,
    OP_HWRST = 3'h4
  } pfc_op_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ISSUE = 5'h02,
    S_WAIT = 5'h04,
    S_PULSE = 5'h08,
    S_RECOV = 5'h10
  } pfc_state_t;
  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_SETUP = 4'h2,
    E_STROBE = 4'h4,
    E_SAMPLE = 4'h8
  } pfc_eng_t;
endpackage

// File: src/pfc_cyc_if.sv
/*
  request and answer group between the sequencer and the bus cycle engine.
  assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface pfc_cyc_if;
  import pfc_pkg::*;
  logic req;
  logic is_write;
  logic [FA_W-1:0] addr;
  logic [FD_W-1:0] wdata;
  logic [FD_W-1:0] rdata;
  logic done;
  modport ctl (output req, is_write, addr, wdata, input rdata, done);
  modport eng (input req, is_write, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

// File: src/pfc_cycle.sv
/*
  bus cycle engine: turns one request into one flash write or read cycle.
  assumes the flash data pins are asynchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module pfc_cycle
(
  input wire logic clk_i,
  input wire logic reset_i,
  pfc_cyc_if.eng c,
  output logic [pfc_pkg::FA_W-1:0] flash_addr_o,
  output logic [pfc_pkg::FD_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [pfc_pkg::FD_W-1:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o
);
  import pfc_pkg::*;
  pfc_eng_t st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [FD_W-1:0] s1_q, s2_q, s3_q;
  logic [FD_W-1:0] rdata_q;
  logic done_q;
  wire cnt_last = (cnt_q == CNT_ONE);
  wire sync_agree = (s2_q == s3_q);
  assign c.rdata = rdata_q;
  assign c.done = done_q;
  // ****************************************
  // data pin synchroniser
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    s1_q <= flash_dq_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  // ****************************************
  // cycle sequencing
  // ****************************************
  // address set before the strobe falls, data held past its rise
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_q <= E_IDLE;
      cnt_q <= '0;
      flash_addr_o <= '0;
      flash_dq_o <= '0;
      flash_dq_oe_o <= 1'b0;
      flash_ce_n_o <= 1'b1;
      flash_oe_n_o <= 1'b1;
      flash_we_n_o <= 1'b1;
      rdata_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        E_IDLE:
        begin
          if (c.req)
          begin
            flash_addr_o <= c.addr;
            flash_dq_o <= c.wdata;
            flash_dq_oe_o <= c.is_write;
            flash_ce_n_o <= 1'b0;
            flash_oe_n_o <= c.is_write;
            cnt_q <= c.is_write ? CYC_SETUP : CYC_RD;
            st_q <= c.is_write ? E_SETUP : E_SAMPLE;
          end
        end
        E_SETUP:
        begin
          if (cnt_last)
          begin
            flash_we_n_o <= 1'b0;
            cnt_q <= CYC_WP;
            st_q <= E_STROBE;
          end
          else
            cnt_q <= cnt_q - CNT_ONE;
        end
        E_STROBE:
        begin
          if (cnt_last)
          begin
            flash_we_n_o <= 1'b1;
            cnt_q <= CNT_ONE;
            st_q <= E_SAMPLE;
          end
          else
            cnt_q <= cnt_q - CNT_ONE;
        end
        E_SAMPLE:
        begin
          if (!cnt_last)
            cnt_q <= cnt_q - CNT_ONE;
          else if (sync_agree || flash_oe_n_o)
          begin
            if (!flash_oe_n_o)
              rdata_q <= s3_q;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_dq_oe_o <= 1'b0;
            done_q <= 1'b1;
            st_q <= E_IDLE;
          end
        end
        default:
          st_q <= E_IDLE;
      endcase
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_we_fall;
    $fell(flash_we_n_o) ##1 !flash_we_n_o;
  endsequence
  chk_write_qualify: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o)
    else $error("write strobe low without select and disabled outputs");
  chk_addr_stable: assert property (s_we_fall |-> $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("address or data moved during write strobe");
  chk_data_hold: assert property ($rose(flash_we_n_o) |-> flash_dq_oe_o && !flash_ce_n_o ##1 $stable(flash_dq_o))
    else $error("data or select released at strobe rise");
  chk_pulse_width: assert property ($fell(flash_we_n_o) |-> (!flash_we_n_o)[*2] ##1 flash_we_n_o)
    else $error("write strobe width wrong");
endmodule
`default_nettype wire

// File: src/pfc_host.sv
/*
  host controller for a byte-wide parallel flash: software orders reads,
  reset command, autoselect entry, byte program and hardware reset pulses.
  assumes a plain register port, one clock, and an external switch that puts
  the high voltage on the flash reset pin while vid_req_o is high.
*/
`timescale 1ns/100ps
`default_nettype none
module pfc_host
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [pfc_pkg::RA_W-1:0] reg_addr_i,
  input wire logic [pfc_pkg::RD_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pfc_pkg::RD_W-1:0] reg_rdata_o,
  output logic [pfc_pkg::FA_W-1:0] flash_addr_o,
  output logic [pfc_pkg::FD_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [pfc_pkg::FD_W-1:0] flash_dq_i,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_reset_n_o,
  output logic vid_req_o
);
  import pfc_pkg::*;
  pfc_cyc_if cyc();
  pfc_state_t st_q;
  pfc_op_t op_q;
  logic [FA_W-1:0] addr_q, caddr_q;
  logic [FD_W-1:0] data_q, cwd_q, rd_q;
  logic [2:0] step_q, wcnt_q;
  logic [CNT_W-1:0] cnt_q;
  logic req_q, iswr_q, poll_q, fail_seen_q;
  logic unprot_q, auto_q, err_q;
  // ****************************************
  // command sequence tables
  // ****************************************
  function automatic logic [2:0] nsteps(input pfc_op_t op);
    case (op)
      OP_AUTO: nsteps = 3'h3;
      OP_PROG: nsteps = PROG_WRITES;
      default: nsteps = 3'h1;
    endcase
  endfunction
  // unlock cycles first, then command, then target
  function automatic logic [FA_W-1:0] step_addr(input pfc_op_t op, input logic [2:0] s,
                                                input logic [FA_W-1:0] a);
    if (op == OP_READ || op == OP_RESET || s > STEP_LAST_UNLOCK)
      step_addr = a;
    else if (s == 3'h1)
      step_addr = UNLOCK_A2;
    else
      step_addr = UNLOCK_A1;
  endfunction
  function automatic logic [FD_W-1:0] step_data(input pfc_op_t op, input logic [2:0] s,
                                                input logic [FD_W-1:0] d);
    if (op == OP_RESET)
      step_data = CMD_RESET;
    else if (s == 3'h0)
      step_data = UNLOCK_D1;
    else if (s == 3'h1)
      step_data = UNLOCK_D2;
    else if (s == STEP_LAST_UNLOCK)
      step_data = (op == OP_AUTO) ? CMD_AUTO : CMD_PROG;
    else
      step_data = d;
  endfunction
  // ****************************************
  // register decode
  // ****************************************
  wire wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire wr_addr = reg_wr_i && (reg_addr_i == REG_ADDR);
  wire wr_data = reg_wr_i && (reg_addr_i == REG_DATA);
  wire idle = (st_q == S_IDLE);
  wire pfc_op_t new_op = pfc_op_t'(reg_wdata_i[CTRL_OP_LSB +: 3]);
  wire op_known = (new_op == OP_READ) || (new_op == OP_RESET) || (new_op == OP_AUTO) ||
                  (new_op == OP_PROG) || (new_op == OP_HWRST);
  // autoselect must be left by the reset command or a hardware reset pulse before a new sequence
  wire op_blocked = auto_q && ((new_op == OP_AUTO) || (new_op == OP_PROG));
  wire start = wr_ctrl && idle && op_known && !op_blocked;
  wire refuse = wr_ctrl && idle && (!op_known || op_blocked);
  wire hw_go = start && (new_op == OP_HWRST);
  wire cnt_last = (cnt_q == CNT_ONE);
  wire last_step = ((step_q + 3'h1) == nsteps(op_q));
  wire poll_match = (cyc.rdata[POLL_BIT] == data_q[POLL_BIT]);
  wire fail_hit = (st_q == S_WAIT) && cyc.done && poll_q && !poll_match &&
                  cyc.rdata[FAIL_BIT] && fail_seen_q;
  // high voltage only while the reset pin is not being pulled low
  wire vid_d = unprot_q && !hw_go && (st_q != S_PULSE);
  wire [RD_W-1:0] stat_word = {20'h00000, unprot_q, auto_q, err_q, !idle, rd_q};
  wire [RD_W-1:0] rd_sel = (reg_addr_i == REG_CTRL) ? {28'h0000000, unprot_q, op_q} :
                           (reg_addr_i == REG_ADDR) ? {14'h0000, addr_q} :
                           (reg_addr_i == REG_DATA) ? {24'h000000, data_q} :
                           (reg_addr_i == REG_STAT) ? stat_word : '0;
  assign cyc.req = req_q;
  assign cyc.is_write = iswr_q;
  assign cyc.addr = caddr_q;
  assign cyc.wdata = cwd_q;
  // ****************************************
  // software registers
  // ****************************************
  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= '0;
      addr_q <= '0;
      data_q <= '0;
      unprot_q <= 1'b0;
      vid_req_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= reg_rd_i ? rd_sel : '0;
      if (wr_addr && idle)
        addr_q <= reg_wdata_i[FA_W-1:0];
      if (wr_data && idle)
        data_q <= reg_wdata_i[FD_W-1:0];
      if (wr_ctrl)
        unprot_q <= reg_wdata_i[CTRL_UNPROT_BIT];
      vid_req_o <= vid_d;
    end
  end
  // ****************************************
  // operation sequencer
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      step_q <= '0;
      wcnt_q <= '0;
      cnt_q <= '0;
      req_q <= 1'b0;
      iswr_q <= 1'b0;
      caddr_q <= '0;
      cwd_q <= '0;
      poll_q <= 1'b0;
      fail_seen_q <= 1'b0;
      auto_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= '0;
      flash_reset_n_o <= 1'b1;
    end
    else
    begin
      req_q <= 1'b0;
      if (cyc.done && iswr_q)
        wcnt_q <= wcnt_q + 3'h1;
      case (st_q)
        S_IDLE:
        begin
          if (refuse)
            err_q <= 1'b1;
          if (start)
          begin
            op_q <= new_op;
            step_q <= '0;
            wcnt_q <= '0;
            err_q <= 1'b0;
            fail_seen_q <= 1'b0;
            poll_q <= 1'b0;
            if (hw_go)
            begin
              flash_reset_n_o <= 1'b0;
              cnt_q <= CYC_RP;
              st_q <= S_PULSE;
            end
            else
              st_q <= S_ISSUE;
          end
        end
        S_ISSUE:
        begin
          req_q <= 1'b1;
          iswr_q <= !poll_q && (op_q != OP_READ);
          caddr_q <= poll_q ? addr_q : step_addr(op_q, step_q, addr_q);
          cwd_q <= step_data(op_q, step_q, data_q);
          st_q <= S_WAIT;
        end
        S_WAIT:
        begin
          if (cyc.done && poll_q)
          begin
            rd_q <= cyc.rdata;
            if (poll_match)
            begin
              poll_q <= 1'b0;
              st_q <= S_IDLE;
            end
            else if (fail_hit)
            begin
              err_q <= 1'b1;
              poll_q <= 1'b0;
              op_q <= OP_RESET;
              step_q <= '0;
              st_q <= S_ISSUE;
            end
            else
            begin
              fail_seen_q <= cyc.rdata[FAIL_BIT];
              st_q <= S_ISSUE;
            end
          end
          else if (cyc.done && last_step)
          begin
            if (op_q == OP_READ)
              rd_q <= cyc.rdata;
            if (op_q == OP_AUTO)
              auto_q <= 1'b1;
            if (op_q == OP_RESET)
              auto_q <= 1'b0;
            poll_q <= (op_q == OP_PROG);
            st_q <= (op_q == OP_PROG) ? S_ISSUE : S_IDLE;
          end
          else if (cyc.done)
          begin
            step_q <= step_q + 3'h1;
            st_q <= S_ISSUE;
          end
        end
        S_PULSE:
        begin
          if (cnt_last)
          begin
            flash_reset_n_o <= 1'b1;
            auto_q <= 1'b0;
            cnt_q <= CYC_RH;
            st_q <= S_RECOV;
          end
          else
            cnt_q <= cnt_q - CNT_ONE;
        end
        S_RECOV:
        begin
          if (cnt_last)
            st_q <= S_IDLE;
          else
            cnt_q <= cnt_q - CNT_ONE;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
  pfc_cycle u_cycle
  (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .c(cyc.eng),
    .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o),
    .flash_dq_i(flash_dq_i),
    .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o)
  );
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire auto_clr_ok = (op_q == OP_RESET) || (st_q == S_PULSE);
  sequence s_reset_issue;
    (st_q == S_ISSUE && op_q == OP_RESET) ##1 (req_q && iswr_q && cwd_q == CMD_RESET);
  endsequence
  chk_vid_reset: assert property (vid_req_o |-> flash_reset_n_o)
    else $error("high voltage requested while reset pin low");
  chk_prog_four: assert property ($rose(poll_q) |-> wcnt_q == 3'h4)
    else $error("program polling began without four writes");
  chk_unlock_first: assert property (req_q && iswr_q && step_q == 3'h0 &&
                                     (op_q == OP_AUTO || op_q == OP_PROG) |->
                                     caddr_q == UNLOCK_A1 && cwd_q == UNLOCK_D1)
    else $error("first unlock cycle has wrong address or data");
  chk_auto_exit: assert property ($fell(auto_q) |-> $past(auto_clr_ok))
    else $error("autoselect left without reset command or pulse");
  chk_fail_reset: assert property (fail_hit |=> s_reset_issue)
    else $error("timing failure not followed by reset command");
endmodule
`default_nettype wire

// File: bench/pfc_flash_model.sv
/*
  behavioural byte-wide flash standing on the far side of pfc_host.
  assumes the bench feeds it the resolved data pins and a protect mask.
*/
`timescale 1ns/100ps
`default_nettype none
module pfc_flash_model
#(
  parameter int PROG_NS = 3000,
  parameter logic [7:0] MAKER_ID = 8'h5c, // arbitrary
  parameter logic [7:0] DEV_ID = 8'ha3, // arbitrary
  parameter logic [7:0] CONT_ID = 8'h6e // arbitrary
)
(
  input wire logic [17:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic vid_i,
  input wire logic [6:0] prot_i
);
  logic [7:0] mem [int];
  logic [7:0] dout = 8'h00;
  logic [7:0] pd = 8'h00;
  logic [17:0] la;
  int step = 0;
  logic act = 0, auto_m = 0, busy = 0, fail = 0, tog = 0;
  realtime t_fall, done_t;
  // ****************************************
  // sector map and array
  // ****************************************
  function automatic int sect(input logic [17:0] a);
    if (a[17:16] != 2'b11)
      return int'(a[17:16]);
    if (!a[15])
      return 3;
    if (a[14])
      return 6;
    return a[13] ? 5 : 4;
  endfunction
  // unwritten bytes read as erased
  function automatic logic [7:0] rd(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // command decoding, one write at a time
  task automatic do_write(input logic [17:0] a, input logic [7:0] d);
    if (busy)
    begin
      if (fail && d == 8'hf0)
        {busy, fail} = 2'b00;
    end
    else if (auto_m)
      auto_m = (d != 8'hf0);
    else if (step == 3)
    begin
      step = 0;
      if (!prot_i[sect(a)] || vid_i)
      begin
        pd = d;
        fail = |(d & ~rd(a));
        mem[a] = rd(a) & d;
        busy = 1'b1;
        done_t = $realtime + PROG_NS;
      end
    end
    else if (d == 8'hf0)
      step = 0;
    else if (step == 0 && a[10:0] == 11'h555 && d == 8'haa)
      step = 1;
    else if (step == 1 && a[10:0] == 11'h2aa && d == 8'h55)
      step = 2;
    else if (step == 2 && a[10:0] == 11'h555 && d == 8'h90)
    begin
      step = 0;
      auto_m = 1'b1;
    end
    else if (step == 2 && a[10:0] == 11'h555 && d == 8'ha0)
      step = 3;
    else
      step = 0;
  endtask
  // ****************************************
  // strobes and pins
  // ****************************************
  // address taken at the later falling strobe; early writes refused
  always @(negedge we_n_i or negedge ce_n_i)
  begin
    if (!we_n_i && !ce_n_i && oe_n_i && reset_n_i && $realtime > 100.0)
    begin
      la = addr_i;
      t_fall = $realtime;
      act = 1'b1;
    end
  end
  // data taken at the first rising strobe; short pulses do nothing
  always @(posedge we_n_i or posedge ce_n_i)
  begin
    if (act && $realtime - t_fall >= 5.0)
      do_write(la, dq_i);
    act = 1'b0;
  end
  // low reset pin ends everything and returns to array reads
  always @(negedge reset_n_i)
  begin
    {busy, fail, auto_m, act} = 4'h0;
    step = 0;
  end
  // read byte chosen once the address has settled
  always @(negedge oe_n_i)
  begin
    #1;
    if (busy && !fail && $realtime >= done_t)
      busy = 1'b0;
    tog = ~tog;
    if (busy)
      dout = {~pd[7], tog, fail, 5'h00};
    else if (auto_m)
      case (addr_i[7:0])
        8'h00: dout = MAKER_ID;
        8'h01: dout = DEV_ID;
        8'h02: dout = {7'h00, prot_i[sect(addr_i)]};
        8'h03: dout = CONT_ID;
        default: dout = 8'h00;
      endcase
    else
      dout = rd(addr_i);
  end
  // released pins show the inverse of the last byte
  assign dq_o = (!ce_n_i && !oe_n_i && reset_n_i) ? dout : ~dout;
endmodule
`default_nettype wire

// File: bench/pfc_host_bench.sv
/*
  self-checking bench for pfc_host with a behavioural flash.
  assumes the register map and status layout of pfc_pkg.
*/
`timescale 1ns/100ps
`default_nettype none
module pfc_host_bench;
  import pfc_pkg::*;
  localparam logic [7:0] MK = 8'h5c; // arbitrary
  localparam logic [7:0] DV = 8'ha3; // arbitrary
  localparam logic [7:0] CT = 8'h6e; // arbitrary
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [RA_W-1:0] reg_addr_i = '0;
  logic [RD_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [RD_W-1:0] reg_rdata_o, stat;
  logic [FA_W-1:0] fa;
  logic [FD_W-1:0] fq_o, fq_i, mq;
  logic fq_oe, ce_n, oe_n, we_n, rst_n, vid;
  logic [6:0] prot = 7'h00;
  int num_errors = 0;
  int samples_checked = 0;
  int low_cnt = 0;
  always #10 clk_i = ~clk_i;
  // shared data pins: host while enabled, else the flash
  assign fq_i = fq_oe ? fq_o : mq;
  always @(posedge clk_i) if (!rst_n) low_cnt++;
  pfc_host u_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .flash_addr_o(fa), .flash_dq_o(fq_o), .flash_dq_oe_o(fq_oe),
    .flash_dq_i(fq_i), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n),
    .flash_reset_n_o(rst_n), .vid_req_o(vid));
  pfc_flash_model #(.MAKER_ID(MK), .DEV_ID(DV), .CONT_ID(CT)) u_flash (.addr_i(fa),
    .dq_i(fq_i), .dq_o(mq), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .reset_n_i(rst_n), .vid_i(vid), .prot_i(prot));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reg_wr(input logic [RA_W-1:0] a, input logic [RD_W-1:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [RA_W-1:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 stat = reg_rdata_o;
  endtask
  // order one operation and poll status until idle, bounded
  task automatic run_op(input pfc_op_t op, input logic [FA_W-1:0] a,
                        input logic [FD_W-1:0] d, input logic unp);
    int n;
    n = 0;
    reg_wr(REG_ADDR, RD_W'(a));
    reg_wr(REG_DATA, RD_W'(d));
    reg_wr(REG_CTRL, RD_W'({unp, op}));
    do
    begin
      reg_rd(REG_STAT);
      n++;
    end
    while (stat[STAT_BUSY_BIT] !== 1'b0 && n < 500);
    if (n >= 500)
    begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic rd_chk(input logic [FA_W-1:0] a, input logic [FD_W-1:0] exp);
    run_op(OP_READ, a, 8'h00, 1'b0);
    check(stat[7:0], exp);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset();
    check({ce_n, oe_n, we_n, rst_n, vid, fq_oe}, 6'h3c);
    reg_rd(REG_STAT);
    check(stat, 32'h0);
    reg_rd(4'h2);
    check(stat, 32'h0);
    // an undefined operation code is refused and flagged, the flash bus stays idle
    reg_wr(REG_CTRL, 32'h5);
    reg_rd(REG_STAT);
    check(stat[STAT_ERR_BIT], 1'b1);
    check(stat[STAT_BUSY_BIT], 1'b0);
    check(ce_n, 1'b1);
  endtask
  task automatic s_program();
    for (int i = 0; i < 2; i++)
    begin
      run_op(OP_PROG, i ? 18'h3a456 : 18'h00123, i ? 8'ha5 : 8'h5a, 1'b0);
      check(stat[STAT_ERR_BIT], 1'b0);
    end
    rd_chk(18'h00123, 8'h5a);
    rd_chk(18'h3a456, 8'ha5);
    rd_chk(18'h00124, 8'hff);
  endtask
  task automatic s_zero_one();
    run_op(OP_PROG, 18'h10010, 8'h00, 1'b0);
    run_op(OP_PROG, 18'h10010, 8'hff, 1'b0);
    check(stat[STAT_ERR_BIT], 1'b1);
    rd_chk(18'h10010, 8'h00);
  endtask
  task automatic s_protect();
    prot = 7'h04;
    run_op(OP_PROG, 18'h20020, 8'h3c, 1'b0);
    rd_chk(18'h20020, 8'hff);
    run_op(OP_PROG, 18'h20020, 8'h3c, 1'b1);
    check(vid, 1'b1);
    rd_chk(18'h20020, 8'h3c);
    run_op(OP_PROG, 18'h20021, 8'h3c, 1'b0);
    rd_chk(18'h20021, 8'hff);
  endtask
  task automatic s_auto();
    run_op(OP_AUTO, 18'h0, 8'h0, 1'b0);
    check(stat[STAT_AUTO_BIT], 1'b1);
    rd_chk(18'h00000, MK);
    rd_chk(18'h12301, DV);
    rd_chk(18'h3ff03, CT);
    rd_chk(18'h20002, 8'h01);
    rd_chk(18'h30002, 8'h00);
    rd_chk(18'h00100, MK);
    run_op(OP_PROG, 18'h00200, 8'h11, 1'b0);
    check(stat[STAT_ERR_BIT], 1'b1);
    run_op(OP_RESET, 18'h0, 8'h0, 1'b0);
    check(stat[STAT_AUTO_BIT], 1'b0);
    rd_chk(18'h00123, 8'h5a);
  endtask
  task automatic s_hwreset();
    int base;
    run_op(OP_AUTO, 18'h0, 8'h0, 1'b0);
    base = low_cnt;
    run_op(OP_HWRST, 18'h0, 8'h0, 1'b0);
    check(low_cnt - base, 32'(CYC_RP));
    check(stat[STAT_AUTO_BIT], 1'b0);
    rd_chk(18'h00000, 8'hff);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    s_reset();
    s_program();
    s_zero_one();
    s_protect();
    s_auto();
    s_hwreset();
    complete_run();
  end
endmodule
`default_nettype wire
